/* File: rtl/dual_uart_consts.vh */
// Register indices, field positions, reset values and timing counts for the dual serial port.
// Assumes byte address = 4 x register index on the bus.
`ifndef DUAL_UART_CONSTS_VH
`define DUAL_UART_CONSTS_VH
`define IDX_POWER_CTRL 8'h87
`define IDX_TIMER1_RELOAD 8'h8d
`define IDX_BAUD_CTRL 8'h8e
`define IDX_SERIAL_CTRL0 8'h98
`define IDX_DATA_BUF0 8'h99
`define IDX_INT_ENABLE 8'ha8
`define IDX_IRQ_PRIO 8'hb8
`define IDX_SERIAL_CTRL1 8'hc0
`define IDX_DATA_BUF1 8'hc1
`define IDX_T2_RELOAD_HI 8'hca
`define IDX_T2_RELOAD_LO 8'hcb
`define IDX_EXT_INT_CTRL 8'hd8
`define BIT_RATE_DOUBLER 7
`define BIT_GLOBAL_EN 7
`define BIT_PORT0_EN 3
`define BIT_PORT1_EN 6
`define BIT_PORT0_PRIO 4
`define BIT_PORT1_PRIO 6
`define BIT_MULTIPROC 5
`define BIT_RX_ENABLE 4
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0
`define BIT_T1_RUN 0
`define BIT_T1_FAST 1
`define BIT_P0_T2_SEL 2
`define BIT_T2_RUN 3
`define RST_REG 8'h00
`define VEC_PORT0 8'h23
`define VEC_PORT1 8'h3b
`define T1_DIV_STD 4'hc
`define T1_DIV_FAST 4'h4
`define DIV16_LAST 4'hf
`define FRAME_BITS 4'ha
`define STOP_IDX 4'h9
`define SAMPLE_A 4'h7
`define SAMPLE_C 4'h9
`define TX_DONE_DELAY 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: rtl/uart_tx_shifter.v */
// Mode 1 transmitter: start, 8 data bits LSB first, stop.
// Assumes tick_i is the 16x baud enable from the same clock.
`timescale 1ns/1ps
`include "dual_uart_consts.vh"
module uart_tx_shifter (
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire load_i,
	input wire [7:0] data_i,
	output reg txd_o,
	output wire done_o
);
	reg [3:0] div_r;
	reg [3:0] cnt_r;
	reg [9:0] shift_r;
	reg busy_r;
	reg pend_r;
	reg [`TX_DONE_DELAY-1:0] dly_r;
	wire roll = tick_i & (div_r == `DIV16_LAST);
	assign done_o = dly_r[`TX_DONE_DELAY-1];
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_r <= 4'h0;
			cnt_r <= 4'h0;
			shift_r <= 10'h3ff;
			busy_r <= 1'b0;
			pend_r <= 1'b0;
			dly_r <= {`TX_DONE_DELAY{1'b0}};
			txd_o <= 1'b1;
		end else begin
			if (tick_i)
				div_r <= div_r + 4'h1;
			dly_r <= {dly_r[`TX_DONE_DELAY-2:0], 1'b0};
			// A write during a frame is dropped: one byte in flight only
			if (load_i & ~busy_r & ~pend_r) begin
				shift_r <= {1'b1, data_i, 1'b0};
				pend_r <= 1'b1;
			end
			if (roll) begin
				if (pend_r) begin
					pend_r <= 1'b0;
					busy_r <= 1'b1;
					txd_o <= shift_r[0];
					shift_r <= {1'b1, shift_r[9:1]};
					cnt_r <= 4'h1;
				end else if (busy_r) begin
					if (cnt_r == `FRAME_BITS) begin
						busy_r <= 1'b0;
						dly_r[0] <= 1'b1;
					end else begin
						txd_o <= shift_r[0];
						shift_r <= {1'b1, shift_r[9:1]};
						cnt_r <= cnt_r + 4'h1;
					end
				end
			end
		end
	end
endmodule

/* File: rtl/uart_rx_sampler.v */
// Mode 1 receiver with 16x oversampling, 3-sample vote and start check.
// Assumes rxd_i is already synchronised to clk_i.
`timescale 1ns/1ps
`include "dual_uart_consts.vh"
module uart_rx_sampler (
	input wire clk_i,
	input wire rst_i,
	input wire tick_i,
	input wire enable_i,
	input wire rxd_i,
	input wire flag_busy_i,
	input wire check_stop_i,
	output reg [7:0] data_o,
	output reg stop_o,
	output reg store_o
);
	reg active_r;
	reg prev_r;
	reg [3:0] div_r;
	reg [3:0] idx_r;
	reg [1:0] vote_r;
	reg [7:0] shift_r;
	wire maj = (vote_r[1] & vote_r[0]) | (vote_r[1] & rxd_i) | (vote_r[0] & rxd_i);
	wire mid = div_r >= `SAMPLE_A && div_r <= `SAMPLE_C;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_r <= 1'b0;
			prev_r <= 1'b1;
			div_r <= 4'h0;
			idx_r <= 4'h0;
			vote_r <= 2'b11;
			shift_r <= 8'h00;
			data_o <= 8'h00;
			stop_o <= 1'b0;
			store_o <= 1'b0;
		end else begin
			prev_r <= rxd_i;
			store_o <= 1'b0;
			if (~enable_i) begin
				active_r <= 1'b0;
			end else if (~active_r) begin
				if (prev_r & ~rxd_i) begin
					active_r <= 1'b1;
					div_r <= 4'h0;
					idx_r <= 4'h0;
				end
			end else if (tick_i) begin
				div_r <= div_r + 4'h1;
				if (mid)
					vote_r <= {vote_r[0], rxd_i};
				if (div_r == `SAMPLE_C) begin
					idx_r <= idx_r + 4'h1;
					if (idx_r == 4'h0) begin
						if (maj)
							active_r <= 1'b0;
					end else if (idx_r == `STOP_IDX) begin
						active_r <= 1'b0;
						// Failing frames leave buffer and stop copy alone
						if (~flag_busy_i & (~check_stop_i | maj)) begin
							data_o <= shift_r;
							stop_o <= maj;
							store_o <= 1'b1;
						end
					end else begin
						shift_r <= {maj, shift_r[7:1]};
					end
				end
			end
		end
	end
endmodule

/* File: rtl/dual_uart.v */
// Two mode 1 serial ports with Timer 1 baud source (Timer 2 on port 0 only) and interrupt gating.
// Assumes an AXI4-Lite master on REF_CLK_I; remote devices on the pins run their own clocks.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "dual_uart_consts.vh"
module dual_uart #(
	parameter ADDR_W = 10
) (
	input wire REF_CLK_I,
	input wire RST_I,
	input wire [ADDR_W-1:0] S_AXI_AWADDR_I,
	input wire S_AXI_AWVALID_I,
	output reg S_AXI_AWREADY_O,
	input wire [31:0] S_AXI_WDATA_I,
	input wire [3:0] S_AXI_WSTRB_I,
	input wire S_AXI_WVALID_I,
	output reg S_AXI_WREADY_O,
	output reg [1:0] S_AXI_BRESP_O,
	output reg S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire [ADDR_W-1:0] S_AXI_ARADDR_I,
	input wire S_AXI_ARVALID_I,
	output reg S_AXI_ARREADY_O,
	output reg [31:0] S_AXI_RDATA_O,
	output reg [1:0] S_AXI_RRESP_O,
	output reg S_AXI_RVALID_O,
	input wire S_AXI_RREADY_I,
	input wire PORT0_RX_PIN_I,
	input wire PORT1_RX_PIN_I,
	output wire PORT0_TX_PIN_O,
	output wire PORT1_TX_PIN_O,
	output wire PORT0_IRQ_O,
	output wire PORT1_IRQ_O,
	output wire PORT0_HIGH_PRIORITY_O,
	output wire PORT1_HIGH_PRIORITY_O,
	output reg [7:0] IRQ_VECTOR_O
);
	reg [7:0] power_control_reg;
	reg [7:0] ext_interrupt_control_reg;
	reg [7:0] interrupt_enable_reg;
	reg [7:0] irq_priority_reg;
	reg [7:0] timer1_reload_byte;
	reg [7:0] timer2_reload_high;
	reg [7:0] timer2_reload_low;
	reg [7:0] baud_ctrl_r;
	reg [ADDR_W-1:0] awaddr_r;
	reg aw_hold_r;
	reg [7:0] wdata_r;
	reg w_strb0_r;
	reg w_hold_r;
	reg [3:0] t1_pre_r;
	reg [7:0] t1_cnt_r;
	reg t1_ovf_r;
	reg t2_pre_r;
	reg [15:0] t2_cnt_r;
	reg t2_ovf_r;
	reg [7:0] rd_val;
	reg rd_ok;
	reg wr_ok;
	wire [7:0] wr_idx = awaddr_r[9:2];
	wire [7:0] rd_idx = S_AXI_ARADDR_I[9:2];
	wire wr_fire = aw_hold_r & w_hold_r & ~S_AXI_BVALID_O;
	wire wr_en = wr_fire & w_strb0_r;
	wire t1_fast = baud_ctrl_r[`BIT_T1_FAST];
	wire [3:0] t1_div = t1_fast ? `T1_DIV_FAST : `T1_DIV_STD;
	wire [1:0] irq_raw;
	wire [1:0] irq_gate;
	wire [1:0] txd;
	wire [1:0] irq_q;
	wire [1:0] prio_q;
	wire [7:0] serial_control_reg_q [0:1];
	wire [7:0] rxbuf_q [0:1];
	assign PORT0_TX_PIN_O = txd[0];
	assign PORT1_TX_PIN_O = txd[1];
	assign PORT0_IRQ_O = irq_q[0];
	assign PORT1_IRQ_O = irq_q[1];
	assign PORT0_HIGH_PRIORITY_O = prio_q[0];
	assign PORT1_HIGH_PRIORITY_O = prio_q[1];
	assign irq_gate[0] = irq_raw[0] & interrupt_enable_reg[`BIT_PORT0_EN]
		& interrupt_enable_reg[`BIT_GLOBAL_EN];
	assign irq_gate[1] = irq_raw[1] & interrupt_enable_reg[`BIT_PORT1_EN]
		& interrupt_enable_reg[`BIT_GLOBAL_EN];

	// Timer 1 in 8-bit auto-reload; other counting modes are not modelled
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			t1_pre_r <= 4'h0;
			t1_cnt_r <= 8'h00;
			t1_ovf_r <= 1'b0;
		end else begin
			t1_ovf_r <= 1'b0;
			if (~baud_ctrl_r[`BIT_T1_RUN]) begin
				t1_pre_r <= 4'h0;
			end else if (t1_pre_r >= t1_div - 4'h1) begin
				t1_pre_r <= 4'h0;
				if (t1_cnt_r == 8'hff) begin
					t1_cnt_r <= timer1_reload_byte;
					t1_ovf_r <= 1'b1;
				end else begin
					t1_cnt_r <= t1_cnt_r + 8'h01;
				end
			end else begin
				t1_pre_r <= t1_pre_r + 4'h1;
			end
		end
	end

	// Timer 2 counts at clk/2 and reloads all 16 bits
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			t2_pre_r <= 1'b0;
			t2_cnt_r <= 16'h0000;
			t2_ovf_r <= 1'b0;
		end else begin
			t2_ovf_r <= 1'b0;
			if (~baud_ctrl_r[`BIT_T2_RUN]) begin
				t2_pre_r <= 1'b0;
				// Parked at the reload so the first period is already the programmed one
				t2_cnt_r <= {timer2_reload_high, timer2_reload_low};
			end else begin
				t2_pre_r <= ~t2_pre_r;
				if (t2_pre_r) begin
					if (t2_cnt_r == 16'hffff) begin
						t2_cnt_r <= {timer2_reload_high, timer2_reload_low};
						t2_ovf_r <= 1'b1;
					end else begin
						t2_cnt_r <= t2_cnt_r + 16'h0001;
					end
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gen_port
			reg [2:0] sync_r;
			reg rxd_r;
			reg half_r;
			reg [7:0] serial_control_reg_r;
			reg irq_r;
			reg prio_r;
			wire ovf;
			wire doubler;
			wire tick;
			wire tx_done;
			wire rx_store;
			wire rx_stop;
			wire [7:0] rx_data;
			wire rx_pin = (g == 0) ? PORT0_RX_PIN_I : PORT1_RX_PIN_I;
			wire [7:0] ctrl_idx = (g == 0) ? `IDX_SERIAL_CTRL0 : `IDX_SERIAL_CTRL1;
			wire [7:0] buf_idx = (g == 0) ? `IDX_DATA_BUF0 : `IDX_DATA_BUF1;
			// Port 1 has no Timer 2 path
			assign ovf = (g == 0 && baud_ctrl_r[`BIT_P0_T2_SEL]) ? t2_ovf_r : t1_ovf_r;
			assign doubler = (g == 0) ? power_control_reg[`BIT_RATE_DOUBLER]
				: ext_interrupt_control_reg[`BIT_RATE_DOUBLER];
			// Timer 2 always bypasses the halving stage
			assign tick = ovf & (doubler | half_r | (g == 0 && baud_ctrl_r[`BIT_P0_T2_SEL]));
			assign irq_raw[g] = serial_control_reg_r[`BIT_TX_DONE] | serial_control_reg_r[`BIT_RX_DONE];
			assign irq_q[g] = irq_r;
			assign prio_q[g] = prio_r;
			assign serial_control_reg_q[g] = serial_control_reg_r;
			assign rxbuf_q[g] = rx_data;
			always @(posedge REF_CLK_I or posedge RST_I) begin
				if (RST_I) begin
					sync_r <= 3'b111;
					rxd_r <= 1'b1;
					half_r <= 1'b0;
					serial_control_reg_r <= `RST_REG;
					irq_r <= 1'b0;
					prio_r <= 1'b0;
				end else begin
					// Pin must settle over two stages before it counts
					sync_r <= {sync_r[1:0], rx_pin};
					if (sync_r[1] == sync_r[2])
						rxd_r <= sync_r[2];
					if (ovf)
						half_r <= ~half_r;
					irq_r <= irq_gate[g];
					prio_r <= irq_priority_reg[(g == 0) ? `BIT_PORT0_PRIO : `BIT_PORT1_PRIO];
					if (wr_en && wr_idx == ctrl_idx)
						serial_control_reg_r <= wdata_r;
					// Hardware set wins over a same-cycle software clear
					if (tx_done)
						serial_control_reg_r[`BIT_TX_DONE] <= 1'b1;
					if (rx_store) begin
						serial_control_reg_r[`BIT_RX_DONE] <= 1'b1;
						serial_control_reg_r[`BIT_RX_NINTH] <= rx_stop;
					end
				end
			end
			uart_tx_shifter tx_inst (
				.clk_i(REF_CLK_I),
				.rst_i(RST_I),
				.tick_i(tick),
				.load_i(wr_en && wr_idx == buf_idx),
				.data_i(wdata_r),
				.txd_o(txd[g]),
				.done_o(tx_done)
			);
			uart_rx_sampler rx_inst (
				.clk_i(REF_CLK_I),
				.rst_i(RST_I),
				.tick_i(tick),
				.enable_i(serial_control_reg_r[`BIT_RX_ENABLE]),
				.rxd_i(rxd_r),
				.flag_busy_i(serial_control_reg_r[`BIT_RX_DONE]),
				.check_stop_i(serial_control_reg_r[`BIT_MULTIPROC]),
				.data_o(rx_data),
				.stop_o(rx_stop),
				.store_o(rx_store)
			);
		end
	endgenerate

	// Vector of the winning request: high priority first, then natural order
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			IRQ_VECTOR_O <= 8'h00;
		end else if (irq_gate[1] & irq_priority_reg[`BIT_PORT1_PRIO]
			& ~(irq_gate[0] & irq_priority_reg[`BIT_PORT0_PRIO])) begin
			IRQ_VECTOR_O <= `VEC_PORT1;
		end else if (irq_gate[0]) begin
			IRQ_VECTOR_O <= `VEC_PORT0;
		end else if (irq_gate[1]) begin
			IRQ_VECTOR_O <= `VEC_PORT1;
		end else begin
			IRQ_VECTOR_O <= 8'h00;
		end
	end

	// Write address map check
	always @* begin
		case (wr_idx)
			`IDX_POWER_CTRL, `IDX_TIMER1_RELOAD, `IDX_BAUD_CTRL, `IDX_SERIAL_CTRL0,
			`IDX_DATA_BUF0, `IDX_INT_ENABLE, `IDX_IRQ_PRIO, `IDX_SERIAL_CTRL1,
			`IDX_DATA_BUF1, `IDX_T2_RELOAD_HI, `IDX_T2_RELOAD_LO, `IDX_EXT_INT_CTRL:
				wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Read mux; a data buffer read returns the receive side
	always @* begin
		rd_ok = 1'b1;
		case (rd_idx)
			`IDX_POWER_CTRL: rd_val = power_control_reg;
			`IDX_TIMER1_RELOAD: rd_val = timer1_reload_byte;
			`IDX_BAUD_CTRL: rd_val = baud_ctrl_r;
			`IDX_SERIAL_CTRL0: rd_val = serial_control_reg_q[0];
			`IDX_DATA_BUF0: rd_val = rxbuf_q[0];
			`IDX_INT_ENABLE: rd_val = interrupt_enable_reg;
			`IDX_IRQ_PRIO: rd_val = irq_priority_reg;
			`IDX_SERIAL_CTRL1: rd_val = serial_control_reg_q[1];
			`IDX_DATA_BUF1: rd_val = rxbuf_q[1];
			`IDX_T2_RELOAD_HI: rd_val = timer2_reload_high;
			`IDX_T2_RELOAD_LO: rd_val = timer2_reload_low;
			`IDX_EXT_INT_CTRL: rd_val = ext_interrupt_control_reg;
			default: begin
				rd_val = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	// AXI4-Lite write: address and data taken in either order, one write at a time
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			S_AXI_AWREADY_O <= 1'b1;
			S_AXI_WREADY_O <= 1'b1;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= `RESP_OKAY;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= {ADDR_W{1'b0}};
			wdata_r <= 8'h00;
			w_strb0_r <= 1'b0;
		end else begin
			if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
				awaddr_r <= S_AXI_AWADDR_I;
				aw_hold_r <= 1'b1;
				S_AXI_AWREADY_O <= 1'b0;
			end
			if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
				wdata_r <= S_AXI_WDATA_I[7:0];
				w_strb0_r <= S_AXI_WSTRB_I[0];
				w_hold_r <= 1'b1;
				S_AXI_WREADY_O <= 1'b0;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (S_AXI_BVALID_O & S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
				S_AXI_AWREADY_O <= 1'b1;
				S_AXI_WREADY_O <= 1'b1;
			end
		end
	end

	// Plain control registers
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			power_control_reg <= `RST_REG;
			ext_interrupt_control_reg <= `RST_REG;
			interrupt_enable_reg <= `RST_REG;
			irq_priority_reg <= `RST_REG;
			timer1_reload_byte <= `RST_REG;
			timer2_reload_high <= `RST_REG;
			timer2_reload_low <= `RST_REG;
			baud_ctrl_r <= `RST_REG;
		end else if (wr_en & wr_ok) begin
			case (wr_idx)
				`IDX_POWER_CTRL: power_control_reg <= wdata_r;
				`IDX_EXT_INT_CTRL: ext_interrupt_control_reg <= wdata_r;
				`IDX_INT_ENABLE: interrupt_enable_reg <= wdata_r;
				`IDX_IRQ_PRIO: irq_priority_reg <= wdata_r;
				`IDX_TIMER1_RELOAD: timer1_reload_byte <= wdata_r;
				`IDX_T2_RELOAD_HI: timer2_reload_high <= wdata_r;
				`IDX_T2_RELOAD_LO: timer2_reload_low <= wdata_r;
				`IDX_BAUD_CTRL: baud_ctrl_r <= wdata_r;
				default: baud_ctrl_r <= baud_ctrl_r;
			endcase
		end
	end

	// AXI4-Lite read: answer one cycle after the address is taken
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			S_AXI_ARREADY_O <= 1'b1;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h00000000;
			S_AXI_RRESP_O <= `RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID_I & S_AXI_ARREADY_O) begin
				S_AXI_ARREADY_O <= 1'b0;
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RDATA_O <= {24'h000000, rd_val};
				S_AXI_RRESP_O <= (rd_ok && S_AXI_ARADDR_I[1:0] == 2'b00) ? `RESP_OKAY
					: `RESP_SLVERR;
			end
			if (S_AXI_RVALID_O & S_AXI_RREADY_I) begin
				S_AXI_RVALID_O <= 1'b0;
				S_AXI_ARREADY_O <= 1'b1;
			end
		end
	end
endmodule

/* File: bench/dual_uart_properties.sv */
// Checker of the dual serial port top: bus answers, transmit bit timing and vector choice.
// Assumes every bit period in use is a whole multiple of BIT_CLKS system clocks.
`timescale 1ns/1ps
module dual_uart_checker #(
	parameter BIT_CLKS = 64
) (
	input wire REF_CLK_I,
	input wire RST_I,
	input wire S_AXI_AWVALID_I,
	input wire S_AXI_AWREADY_O,
	input wire S_AXI_WVALID_I,
	input wire S_AXI_WREADY_O,
	input wire S_AXI_BVALID_O,
	input wire S_AXI_BREADY_I,
	input wire S_AXI_ARVALID_I,
	input wire S_AXI_ARREADY_O,
	input wire [31:0] S_AXI_RDATA_O,
	input wire S_AXI_RVALID_O,
	input wire PORT0_TX_PIN_O,
	input wire PORT1_TX_PIN_O,
	input wire PORT0_IRQ_O,
	input wire PORT1_IRQ_O,
	input wire PORT0_HIGH_PRIORITY_O,
	input wire PORT1_HIGH_PRIORITY_O,
	input wire [7:0] IRQ_VECTOR_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	reg [11:0] low0_r;
	reg [11:0] low1_r;
	// Length of the present low run; a run counts start bit plus any zero data bits
	always @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			low0_r <= 12'h000;
			low1_r <= 12'h000;
		end else begin
			low0_r <= PORT0_TX_PIN_O ? 12'h000 : low0_r + 12'h001;
			low1_r <= PORT1_TX_PIN_O ? 12'h000 : low1_r + 12'h001;
		end
	end
	a_tx0_bits: assert property ($rose(PORT0_TX_PIN_O) |->
		low0_r % BIT_CLKS == 0 && low0_r <= 9 * BIT_CLKS) else $error("port 0 low run bad");
	a_tx1_bits: assert property ($rose(PORT1_TX_PIN_O) |->
		low1_r % BIT_CLKS == 0 && low1_r <= 9 * BIT_CLKS) else $error("port 1 low run bad");
	a_wr_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
		S_AXI_WREADY_O |=> !S_AXI_AWREADY_O ##1 S_AXI_BVALID_O) else $error("no write answer");
	a_wr_done: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=>
		!S_AXI_BVALID_O && S_AXI_AWREADY_O) else $error("write answer not closed");
	a_rd_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=>
		S_AXI_RVALID_O && S_AXI_RDATA_O[31:8] == 24'h000000) else $error("bad read answer");
	a_vec_none: assert property ((!PORT0_IRQ_O && !PORT1_IRQ_O) [*2] |->
		IRQ_VECTOR_O == 8'h00) else $error("vector without request");
	a_vec_port0: assert property ((PORT0_IRQ_O && (!PORT1_IRQ_O ||
		PORT0_HIGH_PRIORITY_O || !PORT1_HIGH_PRIORITY_O)) [*2] |-> IRQ_VECTOR_O == 8'h23)
		else $error("port 0 vector wrong");
	a_vec_port1: assert property ((PORT1_IRQ_O && (!PORT0_IRQ_O ||
		PORT1_HIGH_PRIORITY_O && !PORT0_HIGH_PRIORITY_O)) [*2] |-> IRQ_VECTOR_O == 8'h3b)
		else $error("port 1 vector wrong");
	c_both_irq: cover property (PORT0_IRQ_O && PORT1_IRQ_O);
	c_vec_port1: cover property (IRQ_VECTOR_O == 8'h3b);
	c_tx1_frame: cover property ($rose(PORT1_TX_PIN_O));
endmodule

/* File: bench/uart_remote.sv */
// Remote serial device on one port: drives the receive pin, decodes the transmit pin.
// Assumes the bench sets bclk, the bit period in system clocks, while the line is idle.
`timescale 1ns/1ps
module uart_remote (
	input wire clk_i,
	input wire txd_i,
	output reg rxd_o
);
	int bclk = 64;
	logic [7:0] got[$];
	logic [7:0] d;
	initial rxd_o = 1'b1;
	// Start low, 8 bits LSB first, then stop; stop 0 only when asked
	task automatic send(input [7:0] b, input stopv);
		logic [9:0] f;
		f = {stopv, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd_o <= f[i];
			repeat (bclk) @(posedge clk_i);
		end
		rxd_o <= 1'b1;
		@(posedge clk_i);
	endtask
	// Short low spike, too brief to survive a mid-bit vote
	task automatic pulse(input int n);
		rxd_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		rxd_o <= 1'b1;
		repeat (2 * bclk) @(posedge clk_i);
	endtask
	// Mid-bit sampling from the start edge; tolerant of small phase error
	always begin
		@(negedge txd_i);
		repeat (bclk / 2) @(posedge clk_i);
		if (!txd_i) begin
			for (int i = 0; i < 8; i++) begin
				repeat (bclk) @(posedge clk_i);
				d[i] = txd_i;
			end
			repeat (bclk) @(posedge clk_i);
			got.push_back(d);
		end
	end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the dual serial port: bus master, two remote devices, checks.
// Assumes the consts header is on the include path.
`timescale 1ns/1ps
`include "dual_uart_consts.vh"
module testbench;
	logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
	logic [9:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic awready, wready, bvalid, arready, rvalid, tx0, tx1, irq0, irq1, pr0, pr1;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] vec;
	wire rx0, rx1;
	int n_mismatch = 0, checked = 0;
	always #2.5 clk = ~clk;
	dual_uart dual_uart_inst (.REF_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .PORT0_RX_PIN_I(rx0), .PORT1_RX_PIN_I(rx1),
		.PORT0_TX_PIN_O(tx0), .PORT1_TX_PIN_O(tx1), .PORT0_IRQ_O(irq0), .PORT1_IRQ_O(irq1),
		.PORT0_HIGH_PRIORITY_O(pr0), .PORT1_HIGH_PRIORITY_O(pr1), .IRQ_VECTOR_O(vec));
	uart_remote remote0 (.clk_i(clk), .txd_i(tx0), .rxd_o(rx0));
	uart_remote remote1 (.clk_i(clk), .txd_i(tx1), .rxd_o(rx1));
	task automatic chk(input string nm, input [31:0] e, input [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bus tasks start and end just after a rising edge; requests held until taken
	task automatic wr(input [7:0] a, input [7:0] d, input [1:0] er = 2'b00);
		int n = 0;
		awaddr <= {a, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1 && n < 50);
		chk("bvalid", 1, bvalid);
		chk("bresp", er, bresp);
	endtask
	task automatic rd(input [7:0] a, output [7:0] d, input [1:0] er = 2'b00);
		int n = 0;
		araddr <= {a, 2'b00};
		arvalid <= 1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1 && n < 50);
		chk("rvalid", 1, rvalid);
		d = rdata[7:0];
		chk("rresp", er, rresp);
	endtask
	task automatic waitbit(input [7:0] a, input int b);
		logic [7:0] v;
		int n = 0;
		do begin
			rd(a, v);
			n++;
		end while (v[b] !== 1'b1 && n < 2000);
		chk("flag", 1, v[b]);
	endtask
	task automatic close_out;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		close_out;
	end
	initial begin
		logic [7:0] v, e[2];
		logic [7:0] ci[2] = '{`IDX_SERIAL_CTRL0, `IDX_SERIAL_CTRL1};
		logic [7:0] bi[2] = '{`IDX_DATA_BUF0, `IDX_DATA_BUF1};
		logic [7:0] ri[6] = '{`IDX_POWER_CTRL, `IDX_TIMER1_RELOAD, `IDX_BAUD_CTRL,
			`IDX_INT_ENABLE, `IDX_IRQ_PRIO, `IDX_EXT_INT_CTRL};
		logic [7:0] pv[4] = '{8'h00, 8'h40, 8'h10, 8'h50};
		logic [7:0] pe[4] = '{8'h23, 8'h3b, 8'h23, 8'h23};
		logic [7:0] ie[4] = '{8'h48, 8'hc0, 8'h88, 8'hc8};
		logic [7:0] rt[4] = '{8'h03, 8'h00, 8'h01, 8'h80};
		void'($urandom(32'h8e1d));
		repeat (4) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		foreach (ri[i]) begin
			rd(ri[i], v);
			chk("reset", `RST_REG, v);
		end
		rd(8'h01, v, `RESP_SLVERR);
		chk("unmapped", 0, v);
		wr(8'h01, 8'hff, `RESP_SLVERR);
		// Fast auto-reload at FF with doublers set gives 64 clocks a bit
		wr(`IDX_TIMER1_RELOAD, 8'hff);
		wr(`IDX_BAUD_CTRL, 8'h03);
		wr(`IDX_POWER_CTRL, 8'h80);
		wr(`IDX_EXT_INT_CTRL, 8'h80);
		foreach (ci[p]) wr(ci[p], 8'h10);
		wr(`IDX_INT_ENABLE, 8'hc8);
		repeat (1100) @(posedge clk);
		foreach (bi[p]) begin
			e[p] = 8'($urandom);
			wr(bi[p], e[p]);
		end
		foreach (ci[p]) waitbit(ci[p], `BIT_TX_DONE);
		repeat (4) @(posedge clk);
		chk("tx0", e[0], remote0.got.pop_front());
		chk("tx1", e[1], remote1.got.pop_front());
		for (int i = 0; i < 4; i++) begin
			wr(`IDX_IRQ_PRIO, pv[i]);
			repeat (4) @(posedge clk);
			chk("vector", pe[i], vec);
			chk("prio", {pv[i][6], pv[i][4]}, {pr1, pr0});
		end
		for (int i = 0; i < 4; i++) begin
			wr(`IDX_INT_ENABLE, ie[i]);
			repeat (4) @(posedge clk);
			chk("irq", {ie[i][7] & ie[i][6], ie[i][7] & ie[i][3]}, {irq1, irq0});
		end
		foreach (ci[p]) wr(ci[p], 8'h10);
		repeat (4) @(posedge clk);
		chk("irq_clear", 0, {irq1, irq0});
		foreach (bi[p]) e[p] = 8'($urandom);
		fork
			remote0.send(e[0], 1'b1);
			remote1.send(e[1], 1'b1);
		join
		foreach (ci[p]) begin
			waitbit(ci[p], `BIT_RX_DONE);
			rd(bi[p], v);
			chk("rxbuf", e[p], v);
			rd(ci[p], v);
			chk("rxctrl", 8'h15, v);
		end
		// Receive flag still set after the buffer read, so the next frame is lost
		remote0.send(8'ha5, 1'b1);
		repeat (8) @(posedge clk);
		rd(bi[0], v);
		chk("kept", e[0], v);
		wr(ci[0], 8'h10);
		remote0.pulse(8);
		remote0.send(8'h3c, 1'b1);
		waitbit(ci[0], `BIT_RX_DONE);
		rd(bi[0], v);
		chk("after_spike", 8'h3c, v);
		wr(ci[0], 8'h30);
		remote0.send(8'h81, 1'b0);
		repeat (8) @(posedge clk);
		rd(ci[0], v);
		chk("mp_drop", 0, v[0]);
		wr(ci[0], 8'h10);
		remote0.send(8'h81, 1'b0);
		waitbit(ci[0], `BIT_RX_DONE);
		rd(ci[0], v);
		chk("ninth", 0, v[2]);
		// Halved fast rate, then standard speed with doublers set
		for (int i = 0; i < 2; i++) begin
			wr(`IDX_BAUD_CTRL, rt[2 * i]);
			wr(`IDX_POWER_CTRL, rt[2 * i + 1]);
			wr(`IDX_EXT_INT_CTRL, rt[2 * i + 1]);
			foreach (ci[p]) wr(ci[p], 8'h10);
			remote0.bclk = 128 + 64 * i;
			remote1.bclk = 128 + 64 * i;
			repeat (200) @(posedge clk);
			foreach (bi[p]) wr(bi[p], 8'h55);
			foreach (ci[p]) waitbit(ci[p], `BIT_TX_DONE);
			repeat (4) @(posedge clk);
			chk("rate0", 8'h55, remote0.got.pop_front());
			chk("rate1", 8'h55, remote1.got.pop_front());
		end
		// Port 0 on Timer 2 at FFFE gives 64 clocks a bit; port 1 stays on fast Timer 1
		wr(`IDX_T2_RELOAD_HI, 8'hff);
		wr(`IDX_T2_RELOAD_LO, 8'hfe);
		wr(`IDX_BAUD_CTRL, 8'h0f);
		remote0.bclk = 64;
		remote1.bclk = 64;
		foreach (ci[p]) wr(ci[p], 8'h10);
		repeat (200) @(posedge clk);
		foreach (bi[p]) begin
			e[p] = 8'($urandom);
			wr(bi[p], e[p]);
		end
		foreach (ci[p]) waitbit(ci[p], `BIT_TX_DONE);
		repeat (4) @(posedge clk);
		chk("t2_rate0", e[0], remote0.got.pop_front());
		chk("t2_rate1", e[1], remote1.got.pop_front());
		close_out;
	end
endmodule
bind dual_uart dual_uart_checker dual_uart_checker_inst (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
	.S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
	.S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
	.S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
	.S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
	.S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
	.PORT0_TX_PIN_O(PORT0_TX_PIN_O), .PORT1_TX_PIN_O(PORT1_TX_PIN_O),
	.PORT0_IRQ_O(PORT0_IRQ_O), .PORT1_IRQ_O(PORT1_IRQ_O),
	.PORT0_HIGH_PRIORITY_O(PORT0_HIGH_PRIORITY_O), .PORT1_HIGH_PRIORITY_O(PORT1_HIGH_PRIORITY_O),
	.IRQ_VECTOR_O(IRQ_VECTOR_O));
